// ===== hdl/bdb_bridge.sv
// expansion bus dma bridge: page map translation, inbound dma, outbound cpu
// assumes one synchronous clock; memory and expansion bus answer by pulses
`timescale 1ns/1ps
`include "bdb_cfg.svh"
module bdb_bridge (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // configuration
   input wire logic external_access_enable_i,
   input wire logic [13:0] map_base_i,
   // inbound cycles
   input wire logic ib_valid_i,
   input wire logic [21:0] ib_addr_i,
   input wire logic ib_write_i,
   input wire logic ib_block_i,
   input wire logic ib_last_i,
   input wire logic [15:0] ib_wdata_i,
   output logic bus_reply_strobe_o,
   output logic [15:0] ib_rdata_o,
   // main memory dma port
   output bdb_pkg::bdb_mem_s processor_local_bus_o,
   input wire logic mem_ack_i,
   input wire logic mem_nxm_i,
   input wire logic mem_err_i,
   input wire logic [127:0] mem_rdata_i,
   // processor requests and map writes
   input wire logic cpu_req_i,
   input wire logic cpu_io_i,
   input wire logic cpu_write_i,
   input wire logic [28:0] cpu_addr_i,
   input wire logic [31:0] cpu_wdata_i,
   input wire logic map_wr_i,
   input wire logic [12:0] map_wr_idx_i,
   output logic cpu_done_o,
   output logic cpu_err_o,
   output logic [31:0] cpu_rdata_o,
   // outbound expansion bus transfers
   output logic xb_req_o,
   output logic [21:0] xb_addr_o,
   output logic xb_write_o,
   output logic xb_block_o,
   output logic [15:0] xb_wdata_o,
   input wire logic xb_sack_i,
   input wire logic xb_reply_i,
   input wire logic xb_parity_err_i,
   input wire logic [15:0] xb_rdata_i,
   // interrupts and errors
   input wire logic [3:0] bus_interrupt_requests_i,
   input wire logic iack_pend_i,
   output logic [4:0] irq_level_o,
   output bdb_pkg::bdb_err_s err_o
);
   bdb_pkg::bdb_state_e st_q, st_d;
   bdb_pkg::bdb_mem_s mem_q, mem_d;
   bdb_pkg::bdb_err_s err_q, err_d;
   bdb_pkg::bdb_ent_s ent, ent_v [`BDB_CACHE_N];
   logic [`BDB_CACHE_N-1:0] hit_v;
   logic hit, ld_en, ib_new, rb_hit;
   logic [12:0] look, ftag_q, ftag_d;
   logic [28:0] tr;
   logic [4:0] rem;
   logic ib_seen_q, ib_seen_d, cpu_seen_q, cpu_seen_d, fib_q, fib_d, blk_q, blk_d;
   logic reply_q, reply_d, done_q, done_d, cerr_q, cerr_d;
   logic [15:0] ibd_q, ibd_d;
   logic [31:0] crd_q, crd_d;
   logic xreq_q, xreq_d, xw_q, xw_d, sack_q, sack_d, xwr_q, xwr_d, xblk_q, xblk_d;
   logic [21:0] xad_q, xad_d;
   logic [15:0] xwd_q, xwd_d;
   logic [9:0] tmr_q, tmr_d, iak_q, iak_d;
   logic rbv_q, rbv_d;
   logic [18:0] rbt_q, rbt_d;
   logic [15:0] rb_q [4], rb_d [4];
   logic [15:0] wb_q [`BDB_BLK_MAX], wb_d [`BDB_BLK_MAX];
   logic [4:0] wcnt_q, wcnt_d, woff_q, woff_d;
   logic [28:0] wbase_q, wbase_d;
   logic [3:0] rr_q, rr_d;
   logic [4:0] irq_q, irq_d;

   ////////////////////////////////////////////////////////////////////////////
   // page map cache

   assign ib_new = ib_valid_i && !ib_seen_q;
   assign look = ib_new ? ib_addr_i[21:`BDB_PAGE_LSB] : cpu_addr_i[21:`BDB_PAGE_LSB];
   // sixteen slots searched at once, filled round robin
   genvar gi;
   generate
      for (gi = 0; gi < `BDB_CACHE_N; gi++) begin : g_cam
         bdb_cam_slot u_slot (
            .sys_clk_i(sys_clk_i),
            .resetn_i(resetn_i),
            .look_tag_i(look),
            .hit_o(hit_v[gi]),
            .ent_o(ent_v[gi]),
            .load_i(ld_en && (rr_q == 4'(gi))),
            .load_tag_i(ftag_q),
            .load_ent_i({mem_rdata_i[`BDB_MAP_VALID_BIT], mem_rdata_i[19:0]}),
            .inval_i(map_wr_i),
            .inval_tag_i(map_wr_idx_i)
         );
      end
   endgenerate

   // one-hot hit select; the 20-bit page cannot reach local io space
   always_comb begin
      ent = '0;
      for (int i = 0; i < `BDB_CACHE_N; i++) begin
         if (hit_v[i]) begin
            ent = ent_v[i];
         end
      end
   end
   assign hit = |hit_v;
   assign tr = {ent.page, ib_addr_i[`BDB_PAGE_LSB-1:0]};
   assign rb_hit = rbv_q && ib_block_i && !ib_write_i && (ib_addr_i[21:3] == rbt_q);
   assign rem = 5'(wcnt_q - woff_q);

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencer

   always_comb begin
      st_d = st_q;
      mem_d = mem_q;
      err_d = '0;
      ld_en = 1'b0;
      ftag_d = ftag_q;
      fib_d = fib_q;
      blk_d = blk_q;
      ib_seen_d = ib_seen_q && ib_valid_i;
      cpu_seen_d = cpu_seen_q && cpu_req_i;
      reply_d = 1'b0;
      ibd_d = ibd_q;
      done_d = 1'b0;
      cerr_d = 1'b0;
      crd_d = crd_q;
      xreq_d = xreq_q;
      xw_d = xw_q;
      sack_d = sack_q || xb_sack_i;
      tmr_d = xreq_q ? 10'(tmr_q + 10'h001) : tmr_q;
      rbv_d = rbv_q;
      rbt_d = rbt_q;
      rb_d = rb_q;
      wb_d = wb_q;
      wcnt_d = wcnt_q;
      woff_d = woff_q;
      wbase_d = wbase_q;
      unique case (st_q)
         bdb_pkg::ST_IDLE: begin
            if (ib_new) begin
               if (rb_hit && external_access_enable_i) begin
                  reply_d = 1'b1;
                  ibd_d = rb_q[ib_addr_i[2:1]];
                  ib_seen_d = 1'b1;
               end else if (external_access_enable_i) begin
                  if (!hit) begin
                     st_d = bdb_pkg::ST_MAPRD;
                     ftag_d = look;
                     fib_d = 1'b1;
                  end else if (ent.map_ok && ib_write_i) begin
                     reply_d = 1'b1;
                     ib_seen_d = 1'b1;
                     rbv_d = 1'b0;
                     if (ib_block_i) begin
                        wb_d[0] = ib_wdata_i;
                        wcnt_d = 5'h01;
                        woff_d = 5'h00;
                        wbase_d = tr;
                        st_d = ib_last_i ? bdb_pkg::ST_FLUSH : bdb_pkg::ST_IBBLK;
                     end else begin
                        mem_d = {1'b1, 1'b1, bdb_pkg::SZ_WORD, tr, {112'h0, ib_wdata_i}};
                        st_d = bdb_pkg::ST_IBWR;
                     end
                  end else if (ent.map_ok) begin
                     mem_d.req = 1'b1;
                     mem_d.wr = 1'b0;
                     mem_d.size = ib_block_i ? bdb_pkg::SZ_QUAD : bdb_pkg::SZ_WORD;
                     mem_d.addr = ib_block_i ? {tr[28:3], 3'h0} : tr;
                     blk_d = ib_block_i;
                     st_d = bdb_pkg::ST_IBRD;
                  end
               end
            end else if (cpu_req_i && !cpu_seen_q) begin
               if (!cpu_io_i && !hit) begin
                  st_d = bdb_pkg::ST_MAPRD;
                  ftag_d = look;
                  fib_d = 1'b0;
               end else if (!cpu_io_i && ent.map_ok) begin
                  // mapped back into memory whatever the enable says
                  mem_d = {1'b1, cpu_write_i, bdb_pkg::SZ_LONG,
                     ent.page, cpu_addr_i[8:2], 2'h0, 96'h0, cpu_wdata_i};
                  st_d = bdb_pkg::ST_CPUMEM;
               end else begin
                  xreq_d = 1'b1;
                  xw_d = 1'b0;
                  sack_d = 1'b0;
                  tmr_d = 10'h000;
                  st_d = bdb_pkg::ST_XB;
               end
            end
         end
         bdb_pkg::ST_MAPRD: begin
            mem_d = {1'b1, 1'b0, bdb_pkg::SZ_LONG, map_base_i, ftag_q, 2'h0, 128'h0};
            if (mem_ack_i) begin
               mem_d.req = 1'b0;
               st_d = bdb_pkg::ST_IDLE;
               err_d.mem_err = mem_err_i;
               ld_en = !mem_err_i;
               // a failed fetch would loop forever, so give the cycle up
               if (mem_err_i && fib_q) begin
                  ib_seen_d = 1'b1;
               end else if (mem_err_i) begin
                  done_d = 1'b1;
                  cerr_d = 1'b1;
                  cpu_seen_d = 1'b1;
               end
            end
         end
         bdb_pkg::ST_IBRD: begin
            if (mem_ack_i) begin
               mem_d.req = 1'b0;
               st_d = bdb_pkg::ST_IDLE;
               ib_seen_d = 1'b1;
               err_d.mem_err = mem_err_i;
               if (!mem_err_i && !mem_nxm_i) begin
                  reply_d = 1'b1;
                  ibd_d = blk_q ? mem_rdata_i[{ib_addr_i[2:1], 4'h0} +: 16] : mem_rdata_i[15:0];
                  if (blk_q) begin
                     rbv_d = 1'b1;
                     rbt_d = ib_addr_i[21:3];
                     for (int k = 0; k < 4; k++) begin
                        rb_d[k] = mem_rdata_i[16*k +: 16];
                     end
                  end
               end
            end
         end
         bdb_pkg::ST_IBWR: begin
            if (mem_ack_i) begin
               mem_d.req = 1'b0;
               st_d = bdb_pkg::ST_IDLE;
               err_d.mem_err = mem_err_i;
            end
         end
         bdb_pkg::ST_IBBLK: begin
            if (ib_new && ib_block_i && ib_write_i) begin
               wb_d[wcnt_q[3:0]] = ib_wdata_i;
               wcnt_d = 5'(wcnt_q + 5'h01);
               reply_d = 1'b1;
               ib_seen_d = 1'b1;
               if (ib_last_i || (wcnt_q == 5'(`BDB_BLK_MAX - 1))) begin
                  st_d = bdb_pkg::ST_FLUSH;
               end
            end else if (ib_new) begin
               st_d = bdb_pkg::ST_FLUSH; // other cycle waits until the block is stored
            end
         end
         bdb_pkg::ST_FLUSH: begin
            if (mem_ack_i) begin
               mem_d.req = 1'b0;
               err_d.mem_err = mem_err_i;
               woff_d = 5'(woff_q + (5'h01 << mem_q.size));
            end else if (!mem_q.req && (rem == 5'h00)) begin
               st_d = bdb_pkg::ST_IDLE;
            end else if (!mem_q.req) begin
               mem_d.req = 1'b1;
               mem_d.wr = 1'b1;
               // largest size that still fits the words left
               mem_d.size = (rem >= 5'h08) ? bdb_pkg::SZ_OCTA :
                  (rem >= 5'h04) ? bdb_pkg::SZ_QUAD :
                  (rem >= 5'h02) ? bdb_pkg::SZ_LONG : bdb_pkg::SZ_WORD;
               mem_d.addr = 29'(wbase_q + {woff_q, 1'b0});
               for (int k = 0; k < 8; k++) begin
                  mem_d.wdata[16*k +: 16] = wb_q[4'(woff_q + 5'(k))];
               end
            end
         end
         bdb_pkg::ST_CPUMEM: begin
            if (mem_ack_i) begin
               mem_d.req = 1'b0;
               st_d = bdb_pkg::ST_IDLE;
               done_d = 1'b1;
               cpu_seen_d = 1'b1;
               cerr_d = mem_err_i || mem_nxm_i;
               crd_d = mem_rdata_i[31:0];
            end
         end
         bdb_pkg::ST_XB: begin
            if (xreq_q && xb_reply_i) begin
               crd_d[{xw_q, 4'h0} +: 16] = xb_rdata_i;
               err_d.parity = xb_parity_err_i;
               tmr_d = 10'h000;
               xw_d = 1'b1;
               if (xw_q) begin
                  xreq_d = 1'b0;
                  done_d = 1'b1;
                  cpu_seen_d = 1'b1;
                  st_d = bdb_pkg::ST_IDLE;
               end else if (cpu_io_i) begin
                  xreq_d = 1'b0;
                  sack_d = 1'b0;
               end
            end else if (!xreq_q) begin
               xreq_d = 1'b1; // second io word
               tmr_d = 10'h000;
            end else if ((!sack_q && (tmr_q == 10'(`BDB_SACK_CYC))) ||
                  (sack_q && (tmr_q == 10'(`BDB_REPLY_CYC)))) begin
               err_d.nosack = !sack_q;
               err_d.nxm_to = sack_q;
               xreq_d = 1'b0;
               done_d = 1'b1;
               cerr_d = 1'b1;
               cpu_seen_d = 1'b1;
               st_d = bdb_pkg::ST_IDLE;
            end
         end
      endcase
      // word address and data follow the word counter
      xad_d = cpu_io_i ? {`BDB_IO_PAGE_HI, cpu_addr_i[12:2], xw_d, 1'b0} :
         {cpu_addr_i[21:2], xw_d, 1'b0};
      xwd_d = xw_d ? cpu_wdata_i[31:16] : cpu_wdata_i[15:0];
      xwr_d = cpu_write_i;
      xblk_d = !cpu_io_i;
      rr_d = ld_en ? 4'(rr_q + 4'h1) : rr_q;
      // interrupt acknowledge watchdog fires once per stuck acknowledge
      iak_d = !iack_pend_i ? 10'h000 :
         (iak_q == 10'(`BDB_IACK_CYC)) ? iak_q : 10'(iak_q + 10'h001);
      err_d.iack_to = iack_pend_i && (iak_q == 10'(`BDB_IACK_CYC - 1));
      // highest request level wins
      irq_d = 5'h00;
      for (int i = 0; i < 4; i++) begin
         if (bus_interrupt_requests_i[i]) begin
            irq_d = 5'(`BDB_IRQ_BASE + 5'(i));
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= bdb_pkg::ST_IDLE;
         mem_q <= '0;
         err_q <= '0;
         {ftag_q, fib_q, blk_q, ib_seen_q, cpu_seen_q} <= '0;
         {reply_q, ibd_q, done_q, cerr_q, crd_q} <= '0;
         {xreq_q, xw_q, sack_q, xwr_q, xblk_q, xad_q, xwd_q, tmr_q} <= '0;
         {rbv_q, rbt_q, wcnt_q, woff_q, wbase_q, rr_q, irq_q, iak_q} <= '0;
         rb_q <= '{default: 16'h0000};
         wb_q <= '{default: 16'h0000};
      end else begin
         st_q <= st_d;
         mem_q <= mem_d;
         err_q <= err_d;
         {ftag_q, fib_q, blk_q, ib_seen_q, cpu_seen_q} <= {ftag_d, fib_d, blk_d, ib_seen_d, cpu_seen_d};
         {reply_q, ibd_q, done_q, cerr_q, crd_q} <= {reply_d, ibd_d, done_d, cerr_d, crd_d};
         {xreq_q, xw_q, sack_q, xwr_q, xblk_q} <= {xreq_d, xw_d, sack_d, xwr_d, xblk_d};
         {xad_q, xwd_q, tmr_q} <= {xad_d, xwd_d, tmr_d};
         {rbv_q, rbt_q, wcnt_q, woff_q} <= {rbv_d, rbt_d, wcnt_d, woff_d};
         {wbase_q, rr_q, irq_q, iak_q} <= {wbase_d, rr_d, irq_d, iak_d};
         rb_q <= rb_d;
         wb_q <= wb_d;
      end
   end

   assign bus_reply_strobe_o = reply_q;
   assign ib_rdata_o = ibd_q;
   assign processor_local_bus_o = mem_q;
   assign {cpu_done_o, cpu_err_o, cpu_rdata_o} = {done_q, cerr_q, crd_q};
   assign {xb_req_o, xb_addr_o, xb_write_o, xb_block_o, xb_wdata_o} =
      {xreq_q, xad_q, xwr_q, xblk_q, xwd_q};
   assign irq_level_o = irq_q;
   assign err_o = err_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_wr_take;
      st_q == bdb_pkg::ST_IDLE ##1 st_q == bdb_pkg::ST_IBWR;
   endsequence
   sequence s_xb_go;
      st_q == bdb_pkg::ST_IDLE ##1 st_q == bdb_pkg::ST_XB;
   endsequence

   property p_no_enable;
      st_q == bdb_pkg::ST_IDLE && ib_new && !external_access_enable_i |=> !reply_q;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("reply without enable");
   property p_write_reply;
      s_wr_take |-> reply_q && mem_q.wr && mem_q.size == bdb_pkg::SZ_WORD;
   endproperty
   a_write_reply: assert property (p_write_reply) else $error("write not replied first");
   property p_read_nxm;
      st_q == bdb_pkg::ST_IBRD && mem_ack_i && mem_nxm_i |=> !reply_q;
   endproperty
   a_read_nxm: assert property (p_read_nxm) else $error("reply to missing memory");
   property p_map_fetch;
      st_q == bdb_pkg::ST_MAPRD && mem_q.req |->
         mem_q.addr == {map_base_i, ftag_q, 2'h0} && !mem_q.wr && mem_q.size == bdb_pkg::SZ_LONG;
   endproperty
   a_map_fetch: assert property (p_map_fetch) else $error("bad map fetch");
   property p_octa;
      st_q == bdb_pkg::ST_FLUSH && $rose(mem_q.req) && $past(rem) >= 5'h08 |->
         mem_q.size == bdb_pkg::SZ_OCTA;
   endproperty
   a_octa: assert property (p_octa) else $error("octaword not used");
   property p_quad_read;
      st_q == bdb_pkg::ST_IBRD && mem_q.req && blk_q |-> mem_q.size == bdb_pkg::SZ_QUAD;
   endproperty
   a_quad_read: assert property (p_quad_read) else $error("block read not quadword");
   property p_irq_top;
      bus_interrupt_requests_i[3] |=> irq_level_o == 5'h17;
   endproperty
   a_irq_top: assert property (p_irq_top) else $error("top level not 17");
   property p_xb_ends;
      s_xb_go |-> ##[1:600] done_q;
   endproperty
   a_xb_ends: assert property (p_xb_ends) else $error("outbound transfer hung");
   property p_io_single;
      xreq_q && cpu_io_i |-> !xblk_q && xad_q[21:13] == `BDB_IO_PAGE_HI;
   endproperty
   a_io_single: assert property (p_io_single) else $error("io transfer as block");
endmodule

// ===== hdl/bdb_cam_slot.sv
// one fully associative slot of the page map cache
// assumes the owner loads at most one slot per cycle
`timescale 1ns/1ps
module bdb_cam_slot (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // lookup
   input wire logic [12:0] look_tag_i,
   output logic hit_o,
   output bdb_pkg::bdb_ent_s ent_o,
   // fill and invalidate
   input wire logic load_i,
   input wire logic [12:0] load_tag_i,
   input bdb_pkg::bdb_ent_s load_ent_i,
   input wire logic inval_i,
   input wire logic [12:0] inval_tag_i
);
   logic cache_entry_valid_q, cache_entry_valid_d;
   logic [12:0] tag_q, tag_d;
   bdb_pkg::bdb_ent_s ent_q, ent_d;

   // invalidate beats a fill of the same tag so a stale copy never survives
   always_comb begin
      cache_entry_valid_d = cache_entry_valid_q;
      tag_d = tag_q;
      ent_d = ent_q;
      if (load_i) begin
         cache_entry_valid_d = 1'b1;
         tag_d = load_tag_i;
         ent_d = load_ent_i;
      end
      if (inval_i && cache_entry_valid_d && (tag_d == inval_tag_i)) begin
         cache_entry_valid_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cache_entry_valid_q <= 1'b0;
         tag_q <= 13'h0000;
         ent_q <= '0;
      end else begin
         cache_entry_valid_q <= cache_entry_valid_d;
         tag_q <= tag_d;
         ent_q <= ent_d;
      end
   end

   assign hit_o = cache_entry_valid_q && (tag_q == look_tag_i);
   assign ent_o = ent_q;
endmodule

// ===== hdl/bdb_cfg.svh
// constants of the expansion bus dma bridge: field positions, sizes, timing
// assumes a 25 MHz system clock; every cycle count below is derived from it
`ifndef BDB_CFG_SVH
`define BDB_CFG_SVH
`define BDB_CLK_MHZ 25
`define BDB_PAGE_LSB 9
`define BDB_CACHE_N 16
`define BDB_BLK_MAX 16
`define BDB_MAP_VALID_BIT 31
`define BDB_IO_PAGE_HI 9'h1FF
`define BDB_IRQ_BASE 5'h14
`define BDB_SACK_US 5
`define BDB_REPLY_US 5
`define BDB_IACK_US 5
`define BDB_SACK_CYC (`BDB_SACK_US * `BDB_CLK_MHZ)
`define BDB_REPLY_CYC (`BDB_REPLY_US * `BDB_CLK_MHZ)
`define BDB_IACK_CYC (`BDB_IACK_US * `BDB_CLK_MHZ)
`endif

// ===== hdl/bdb_pkg.sv
// types shared by the bridge and its map cache slot
// assumes bdb_cfg.svh holds the numeric constants
package bdb_pkg;
   typedef enum logic [1:0] {
      SZ_WORD = 2'b00,
      SZ_LONG = 2'b01,
      SZ_QUAD = 2'b10,
      SZ_OCTA = 2'b11
   } bdb_size_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MAPRD = 3'b001,
      ST_IBRD = 3'b010,
      ST_IBWR = 3'b011,
      ST_IBBLK = 3'b100,
      ST_FLUSH = 3'b101,
      ST_CPUMEM = 3'b110,
      ST_XB = 3'b111
   } bdb_state_e;
   typedef struct packed {
      logic map_ok;
      logic [19:0] page;
   } bdb_ent_s;
   typedef struct packed {
      logic req;
      logic wr;
      bdb_size_e size;
      logic [28:0] addr;
      logic [127:0] wdata;
   } bdb_mem_s;
   typedef struct packed {
      logic nosack;
      logic iack_to;
      logic nxm_to;
      logic mem_err;
      logic parity;
   } bdb_err_s;
endpackage

// ===== verif/bdb_far_model.sv
// far side of the bridge: main memory holding the page map, expansion bus slave
// assumes the bridge holds each request until answered; map block at map_base_i
`timescale 1ns/1ps
module bdb_far_model (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // main memory side
   input bdb_pkg::bdb_mem_s mem_i,
   input wire logic [13:0] map_base_i,
   output logic mem_ack_o,
   output logic mem_nxm_o,
   output logic [127:0] mem_rdata_o,
   // expansion bus slave side
   input wire logic xb_req_i,
   input wire logic sack_en_i,
   output logic xb_sack_o,
   output logic xb_reply_o,
   output logic [15:0] xb_rdata_o
);
   logic [1:0] mcnt_q;
   logic [2:0] xcnt_q;
   logic wsel_q;
   logic [12:0] idx;
   assign idx = mem_i.addr[14:2];
   assign xb_sack_o = xb_req_i & sack_en_i;
   ////////////////////////////////////////////////////////////////////////////////
   // memory acks two cycles late; even entries valid, idx bit 12 maps above memory
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mcnt_q <= 2'h0;
         mem_ack_o <= 1'b0;
         mem_nxm_o <= 1'b0;
         mem_rdata_o <= 128'h0;
      end else if (mem_i.req && !mem_ack_o && mcnt_q == 2'h1) begin
         mcnt_q <= 2'h0;
         mem_ack_o <= 1'b1;
         mem_nxm_o <= mem_i.addr[28];
         if (mem_i.addr[28:15] == map_base_i)
            mem_rdata_o <= {4{~idx[0], 11'h000, idx[12], 6'h00, idx}};
         else
            mem_rdata_o <= {8{mem_i.addr[15:0]}};
      end else begin
         mcnt_q <= (mem_i.req && !mem_ack_o) ? mcnt_q + 2'h1 : 2'h0;
         mem_ack_o <= 1'b0;
         mem_nxm_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o; // released lines invert every cycle, so old data never stays steady
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // slave replies per word; words alternate so pairing mistakes show up
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xcnt_q <= 3'h0;
         wsel_q <= 1'b0;
         xb_reply_o <= 1'b0;
         xb_rdata_o <= 16'h0;
      end else if (xb_sack_o && (xcnt_q == 3'h2 || xcnt_q == 3'h5)) begin
         xcnt_q <= xcnt_q + 3'h1;
         wsel_q <= ~wsel_q;
         xb_reply_o <= 1'b1;
         xb_rdata_o <= wsel_q ? 16'h5678 : 16'h1234;
      end else begin
         xcnt_q <= xb_sack_o ? xcnt_q + 3'h1 : 3'h0;
         xb_reply_o <= 1'b0;
         xb_rdata_o <= ~xb_rdata_o;
      end
   end
endmodule

// ===== verif/expansion_bus_dma_bridge_bench.sv
// self-checking bench: inbound rows, cpu transfers, timeouts
// assumes bdb_far_model stands in for memory and expansion bus slaves
`timescale 1ns/1ps
module expansion_bus_dma_bridge_bench;
   typedef struct packed {
      logic [3:0] rq;
      logic [4:0] lv;
      logic en;
      logic wr;
      logic [21:0] addr;
      logic rep;
   } bdb_row_s;
   localparam bdb_row_s rows [6] = '{'{4'h0, 5'h00, 1'b1, 1'b1, 22'h00086A, 1'b1},
      '{4'h1, 5'h14, 1'b0, 1'b1, 22'h00086A, 1'b0}, '{4'h3, 5'h15, 1'b1, 1'b1, 22'h000A10, 1'b0},
      '{4'h7, 5'h16, 1'b1, 1'b0, 22'h200400, 1'b0}, '{4'h8, 5'h17, 1'b1, 1'b0, 22'h000870, 1'b1},
      '{4'hF, 5'h17, 1'b1, 1'b1, 22'h200400, 1'b1}};
   logic clk, rst_n, en, ib_v, ib_w, cpu_req, cpu_io, sack_en, iack, got, cerr, blk;
   logic mack, mnxm, xrep, rep, done, cerr_o, xreq, xblk, xb_prev, nosack_seen, iack_seen;
   logic ibb, ibl, mwr, sack;
   logic [13:0] mbase;
   logic [21:0] ib_a;
   logic [28:0] cpu_a, last_waddr;
   logic [3:0] brq;
   logic [31:0] crd, rdata;
   logic [127:0] mrd;
   logic [15:0] xrd, ibd;
   logic [4:0] lvl;
   bdb_pkg::bdb_mem_s mreq;
   bdb_pkg::bdb_err_s errs;
   int fails, comparisons, rises;
   bdb_bridge i_bdb_bridge (.sys_clk_i(clk), .resetn_i(rst_n), .external_access_enable_i(en),
      .map_base_i(mbase), .ib_valid_i(ib_v), .ib_addr_i(ib_a), .ib_write_i(ib_w),
      .ib_block_i(ibb), .ib_last_i(ibl), .ib_wdata_i(16'hBEEF), .bus_reply_strobe_o(rep),
      .ib_rdata_o(ibd), .processor_local_bus_o(mreq), .mem_ack_i(mack), .mem_nxm_i(mnxm),
      .mem_err_i(1'b0), .mem_rdata_i(mrd), .cpu_req_i(cpu_req), .cpu_io_i(cpu_io),
      .cpu_write_i(1'b0), .cpu_addr_i(cpu_a), .cpu_wdata_i(32'h0), .map_wr_i(mwr),
      .map_wr_idx_i(ib_a[21:9]), .cpu_done_o(done), .cpu_err_o(cerr_o), .cpu_rdata_o(rdata),
      .xb_req_o(xreq), .xb_addr_o(), .xb_write_o(), .xb_block_o(xblk), .xb_wdata_o(),
      .xb_sack_i(sack), .xb_reply_i(xrep), .xb_parity_err_i(1'b0), .xb_rdata_i(xrd),
      .bus_interrupt_requests_i(brq), .iack_pend_i(iack), .irq_level_o(lvl), .err_o(errs));
   bdb_far_model i_far (.sys_clk_i(clk), .resetn_i(rst_n), .mem_i(mreq),
      .map_base_i(mbase), .mem_ack_o(mack), .mem_nxm_o(mnxm), .mem_rdata_o(mrd), .xb_rdata_o(xrd),
      .xb_req_i(xreq), .sack_en_i(sack_en), .xb_sack_o(sack), .xb_reply_o(xrep));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, then a watcher of memory writes, expansion requests and error pulses
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      xb_prev <= xreq;
      if (xreq && !xb_prev) begin
         rises = rises + 1;
         blk = xblk;
      end
      if (mreq.req && mreq.wr)
         last_waddr <= mreq.addr;
      if (errs.nosack)
         nosack_seen = 1'b1;
      if (errs.iack_to)
         iack_seen = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared compare, closing report and the two transfer drivers
   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string what);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // no reply within the window is a legal outcome, so this wait is not a timeout
   task automatic ib_cycle(input logic [21:0] a, input logic w, output logic seen);
      seen = 1'b0;
      ib_a = a;
      ib_w = w;
      ib_v = 1'b1;
      for (int n = 0; n < 60 && !seen; n++) begin
         @(negedge clk);
         seen = rep;
      end
      ib_v = 1'b0;
      repeat (12) @(negedge clk);
   endtask
   task automatic cpu_xfer(input logic io, input logic [28:0] a);
      got = 1'b0;
      rises = 0;
      cpu_io = io;
      cpu_a = a;
      cpu_req = 1'b1;
      for (int n = 0; n < 400 && !got; n++) begin
         @(negedge clk);
         got = done;
         cerr = cerr_o;
         crd = rdata;
      end
      cpu_req = 1'b0;
      if (!got) begin
         cmp(32'h0, 32'h1, "cpu transfer never completed");
         wrap_up();
      end
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset, row loop, then hand-written transfers and timeouts
   initial begin
      {rst_n, en, ib_v, ib_w, cpu_req, cpu_io, iack, nosack_seen, iack_seen} = 9'h000;
      {sack_en, blk, xb_prev, ib_a, cpu_a, brq, ibb, ibl, mwr} = '0;
      mbase = 14'h0010;
      repeat (4) @(negedge clk);
      cmp(32'({rep, done, xreq, lvl}), 32'h0, "outputs in reset");
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         brq = rows[i].rq;
         en = rows[i].en;
         @(negedge clk);
         cmp(32'(lvl), 32'(rows[i].lv), "interrupt level");
         ib_cycle(rows[i].addr, rows[i].wr, got);
         cmp(32'(got), 32'(rows[i].rep), "inbound reply");
      end
      cmp(32'(last_waddr), 32'h1020_0400, "translated address");
      cmp(32'(ibd), 32'h0000_0870, "inbound read word");
      // nine block words flush as one octaword and one word; then a fresh and a buffered read
      ibb = 1'b1;
      for (int j = 0; j < 9; j++) begin
         ibl = (j == 8);
         ib_cycle(22'(22'h000800 + 2 * j), 1'b1, got);
         cmp(32'(got), 32'h1, "block word reply");
      end
      cmp(32'(last_waddr), 32'h0000_0810, "block flush tail");
      ib_cycle(22'h000872, 1'b0, got);
      ib_cycle(22'h000874, 1'b0, cerr);
      cmp(32'({got, cerr, ibd}), 32'h0003_0870, "block read and buffered word");
      ibb = 1'b0;
      sack_en = 1'b1;
      cpu_xfer(1'b1, 29'h0000_0010);
      cmp({crd[31:8], 7'(rises), blk}, {24'h5678_12, 8'h04}, "io longword");
      cpu_xfer(1'b0, 29'h0000_0A00);
      cmp({crd[31:8], 7'(rises), blk}, {24'h5678_12, 8'h03}, "block longword");
      en = 1'b0;
      // drop the cached copy so the mapped-back read must fetch the entry again
      ib_a = 22'h000800;
      mwr = 1'b1;
      @(negedge clk);
      mwr = 1'b0;
      cpu_xfer(1'b0, 29'h0000_0820);
      cmp({crd[31:1], cerr}, {31'h0410_0410, 1'b0}, "mapped back read");
      cmp(32'(rises), 32'h0, "mapped back stays off the bus");
      sack_en = 1'b0;
      iack = 1'b1;
      cpu_xfer(1'b1, 29'h0000_0010);
      cmp(32'({cerr, nosack_seen, iack_seen}), 32'h7, "timeouts reported");
      wrap_up();
   end
endmodule
